//--- logic/divider_select_code_pkg.sv
// Constants and carriers for the output channel divider and phase sync logic
// ======================================
package divider_select_code_pkg;
   // ======================================
   // Register map
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_DIVIDER = 8'h04;
   localparam logic [7:0] ADDR_OUTPUT  = 8'h08;
   localparam logic [7:0] ADDR_CAL     = 8'h0C;
   localparam logic [7:0] ADDR_STATUS  = 8'h10;
   localparam logic [7:0] ADDR_SETTLE  = 8'h14;
   // Control fields
   localparam int CTL_SLEEP_BIT = 0;
   localparam int CTL_CAL_BIT   = 1;
   localparam int CTL_SYNC_BIT  = 2;
   localparam int CTL_FRAC_BIT  = 3;
   // Output fields
   localparam int OUT_A_LSB  = 0;
   localparam int OUT_B_LSB  = 2;
   localparam int OUT_PA_LSB = 8;
   localparam int OUT_PB_LSB = 16;
   // Source select encoding
   localparam logic [1:0] SRC_DIVIDER = 2'h0;
   localparam logic [1:0] SRC_DIRECT  = 2'h1;
   localparam logic [1:0] SRC_SYSREF  = 2'h2;
   // Reset values
   localparam logic [31:0] CONTROL_RESET = 32'h00000000;
   localparam logic [31:0] DIVIDER_RESET = 32'h00000000;
   localparam logic [31:0] OUTPUT_RESET  = 32'h00000505;
   localparam logic [31:0] SETTLE_RESET  = 32'h00000040;
   localparam logic [31:0] CAL_RESET     = 32'h00000000;
   localparam logic [4:0]  CODE_MAX      = 5'h11;
   // Timing
   localparam int CLK_MHZ        = 40;
   localparam int CAL_TIME_US    = 20;
   localparam int CAL_CYCLES     = CAL_TIME_US * CLK_MHZ;

   typedef struct packed {
      logic [4:0] first_segment_ratio;
      logic [4:0] second_segment_ratio;
      logic [4:0] third_segment_ratio;
      logic [4:0] fourth_segment_ratio;
   } segments_t;

   typedef enum logic [1:0] {ST_IDLE, ST_CAL, ST_SETTLE, ST_ALIGNED} sync_state_t;
endpackage

//--- logic/output_channel_divider_sync.sv
// Channel divider, output power, power-down and phase sync control with a Wishbone slave
`default_nettype none
module output_channel_divider_sync #(
   parameter int CAL_CYCLES_P = divider_select_code_pkg::CAL_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   input  wire logic        chip_enable_i,
   input  wire logic        reference_input_i,
   input  wire logic        sync_pin_i,
   input  wire logic        vco_in_i,
   output logic             divided_o,
   output logic             divider_powered_o,
   output logic             powered_down_o,
   output logic [9:0]       divider_ratio_o,
   output logic [2:0]       feedback_extra_division_o,
   output logic [5:0]       output_a_current_o,
   output logic [5:0]       output_b_current_o,
   output logic             sync_retimed_o,
   output logic             phase_aligned_o
);
   if (CAL_CYCLES_P < 1) begin : g_chk
      $error("CAL_CYCLES_P must be at least 1");
   end

   // ======================================
   // Bus slave
   logic [31:0] control, divider, outsel, cal, settle;
   wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   wire hit_ctl  = wb_adr_i == divider_select_code_pkg::ADDR_CONTROL;
   wire hit_div  = wb_adr_i == divider_select_code_pkg::ADDR_DIVIDER;
   wire hit_out  = wb_adr_i == divider_select_code_pkg::ADDR_OUTPUT;
   wire hit_cal  = wb_adr_i == divider_select_code_pkg::ADDR_CAL;
   wire hit_sta  = wb_adr_i == divider_select_code_pkg::ADDR_STATUS;
   wire hit_set  = wb_adr_i == divider_select_code_pkg::ADDR_SETTLE;
   wire mapped   = hit_ctl | hit_div | hit_out | hit_cal | hit_sta | hit_set;
   wire wr       = req & wb_we_i & mapped;
   wire [31:0] mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [31:0] m);
      merge = (old & ~m) | (d & m);
   endfunction

   // ======================================
   // Pin synchronisers
   logic [2:0] ce_s, ref_s, syn_s;
   wire ce_lvl  = ce_s[2];
   wire ref_rise = ref_s[1] & ~ref_s[2];
   wire syn_rise = syn_s[1] & ~syn_s[2];

   // ======================================
   // Decode and derived controls
   logic [4:0]  code;
   logic [1:0]  src_a, src_b;
   divider_select_code_pkg::segments_t seg;
   assign code  = divider[4:0];
   assign src_a = outsel[divider_select_code_pkg::OUT_A_LSB +: 2];
   assign src_b = outsel[divider_select_code_pkg::OUT_B_LSB +: 2];

   always_comb begin
      seg = '{5'h02, 5'h01, 5'h01, 5'h01};
      unique case (code)
         5'h00: seg = '{5'h02, 5'h01, 5'h01, 5'h01};
         5'h01: seg = '{5'h02, 5'h02, 5'h01, 5'h01};
         5'h02: seg = '{5'h02, 5'h03, 5'h01, 5'h01};
         5'h03: seg = '{5'h02, 5'h02, 5'h02, 5'h01};
         5'h04: seg = '{5'h02, 5'h03, 5'h02, 5'h01};
         5'h05: seg = '{5'h02, 5'h02, 5'h04, 5'h01};
         5'h06: seg = '{5'h02, 5'h02, 5'h06, 5'h01};
         5'h07: seg = '{5'h02, 5'h02, 5'h08, 5'h01};
         5'h08: seg = '{5'h02, 5'h03, 5'h08, 5'h01};
         5'h09: seg = '{5'h02, 5'h02, 5'h08, 5'h02};
         5'h0A: seg = '{5'h02, 5'h03, 5'h06, 5'h02};
         5'h0B: seg = '{5'h02, 5'h03, 5'h08, 5'h02};
         5'h0C: seg = '{5'h02, 5'h02, 5'h08, 5'h04};
         5'h0D: seg = '{5'h02, 5'h02, 5'h08, 5'h06};
         5'h0E: seg = '{5'h02, 5'h02, 5'h08, 5'h08};
         5'h0F: seg = '{5'h02, 5'h03, 5'h08, 5'h08};
         5'h10: seg = '{5'h02, 5'h02, 5'h08, 5'h10};
         5'h11: seg = '{5'h02, 5'h03, 5'h08, 5'h10};
         default: seg = '{5'h02, 5'h01, 5'h01, 5'h01};
      endcase
   end

   wire [19:0] ratio_full = seg.first_segment_ratio * seg.second_segment_ratio
                          * seg.third_segment_ratio * seg.fourth_segment_ratio;
   wire code_valid = code <= divider_select_code_pkg::CODE_MAX;

   wire sleep = ~ce_lvl | control[divider_select_code_pkg::CTL_SLEEP_BIT];
   wire div_pwr = ~sleep & ((src_a == divider_select_code_pkg::SRC_DIVIDER) |
                  (src_b == divider_select_code_pkg::SRC_DIVIDER) | (src_b == divider_select_code_pkg::SRC_SYSREF));

   wire both_direct = (src_a == divider_select_code_pkg::SRC_DIRECT) & (src_b == divider_select_code_pkg::SRC_DIRECT);
   wire [2:0] extra = ~control[divider_select_code_pkg::CTL_SYNC_BIT] | both_direct ? 3'h1 :
                      (seg.second_segment_ratio == 5'h03) ? 3'h6 : 3'h4;

   // States 32 to 47 mimic 16 to 31
   function automatic logic [5:0] drive(input logic [5:0] lvl);
      drive = (lvl[5:4] == 2'h2) ? {2'h1, lvl[3:0]} : lvl;
   endfunction

   // ======================================
   // Segment counters
   logic [4:0] cnt0, cnt1, cnt2, cnt3;
   logic       q3;
   logic [4:0] last_code;
   logic       vco_d;
   wire vco_edge = vco_in_i & ~vco_d;
   // Clear counters while unpowered, on an invalid code or on code change
   wire hold = ~div_pwr | ~code_valid | (code != last_code);
   wire w0 = cnt0 == seg.first_segment_ratio - 5'h01;
   wire t0 = vco_edge & w0;
   wire w1 = cnt1 == seg.second_segment_ratio - 5'h01;
   wire t1 = t0 & w1;
   wire w2 = cnt2 == seg.third_segment_ratio - 5'h01;
   wire t2 = t1 & w2;
   wire w3 = cnt3 == seg.fourth_segment_ratio - 5'h01;
   wire t3 = t2 & w3;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         {cnt0, cnt1, cnt2, cnt3} <= '0;
         q3 <= 1'b0;
         last_code <= '0;
         vco_d <= 1'b0;
      end else begin
         vco_d <= vco_in_i;
         last_code <= code;
         if (hold) begin
            {cnt0, cnt1, cnt2, cnt3} <= '0;
            q3 <= 1'b0;
         end else begin
            if (vco_edge) cnt0 <= w0 ? 5'h00 : cnt0 + 5'h01;
            if (t0) cnt1 <= w1 ? 5'h00 : cnt1 + 5'h01;
            if (t1) cnt2 <= w2 ? 5'h00 : cnt2 + 5'h01;
            if (t2) cnt3 <= w3 ? 5'h00 : cnt3 + 5'h01;
            q3 <= t3 ? ~q3 : q3;
         end
      end
   end

   // ======================================
   // Sync and calibration sequencer
   divider_select_code_pkg::sync_state_t state;
   logic [15:0] timer;
   logic        sync_pend, sync_bit_d;
   wire cal_kick  = wr & hit_ctl & wb_sel_i[0] & wb_dat_i[divider_select_code_pkg::CTL_CAL_BIT];
   wire sw_sync   = control[divider_select_code_pkg::CTL_SYNC_BIT] & ~sync_bit_d;
   wire [15:0] settle_len = control[divider_select_code_pkg::CTL_FRAC_BIT] ? settle[15:0] + settle[31:16] : settle[15:0];

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ce_s <= '0;
         ref_s <= '0;
         syn_s <= '0;
         control <= divider_select_code_pkg::CONTROL_RESET;
         divider <= divider_select_code_pkg::DIVIDER_RESET;
         outsel <= divider_select_code_pkg::OUTPUT_RESET;
         cal <= divider_select_code_pkg::CAL_RESET;
         settle <= divider_select_code_pkg::SETTLE_RESET;
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= '0;
         state <= divider_select_code_pkg::ST_IDLE;
         timer <= '0;
         sync_pend <= 1'b0;
         sync_retimed_o <= 1'b0;
         sync_bit_d <= 1'b0;
      end else begin
         ce_s <= {ce_s[1:0], chip_enable_i};
         ref_s <= {ref_s[1:0], reference_input_i};
         syn_s <= {syn_s[1:0], sync_pin_i};
         wb_ack_o <= req & mapped;
         wb_err_o <= req & ~mapped;
         sync_bit_d <= control[divider_select_code_pkg::CTL_SYNC_BIT];
         if (wr & hit_ctl) control <= merge(control, wb_dat_i, mask);
         if (wr & hit_div) divider <= merge(divider, wb_dat_i, mask) & 32'h0000001F;
         if (wr & hit_out) outsel <= merge(outsel, wb_dat_i, mask) & 32'h003F3F0F;
         if (wr & hit_cal) cal <= merge(cal, wb_dat_i, mask);
         if (wr & hit_set) settle <= merge(settle, wb_dat_i, mask);
         if (req & ~wb_we_i) begin
            wb_dat_o <= hit_ctl ? control : hit_div ? divider : hit_out ? outsel : hit_cal ? cal :
                        hit_set ? settle : hit_sta ? {24'h0, ~code_valid, div_pwr, sleep,
                        phase_aligned_o, 2'h0, state} : 32'h0;
         end
         sync_retimed_o <= 1'b0;
         if (sync_pend & ref_rise & control[divider_select_code_pkg::CTL_SYNC_BIT]) begin
            sync_pend <= 1'b0;
            sync_retimed_o <= 1'b1;
         end
         // New request in the same cycle as the retime wins, so it is not lost
         if (syn_rise | sw_sync) sync_pend <= 1'b1;
         // Aligned only after calibration and settling
         // Calibration runs its full length from any seed unless sleep returns the state to idle
         if (sleep) begin
            state <= divider_select_code_pkg::ST_IDLE;
         end else begin
            unique case (state)
               divider_select_code_pkg::ST_IDLE, divider_select_code_pkg::ST_ALIGNED: begin
                  if (cal_kick | (sync_retimed_o & control[divider_select_code_pkg::CTL_CAL_BIT])) begin
                     state <= divider_select_code_pkg::ST_CAL;
                     timer <= 16'(CAL_CYCLES_P);
                  end
               end
               divider_select_code_pkg::ST_CAL: begin
                  timer <= timer - 16'h0001;
                  if (timer == 16'h0001) begin
                     state <= divider_select_code_pkg::ST_SETTLE;
                     timer <= (settle_len == 16'h0000) ? 16'h0001 : settle_len;
                  end
               end
               divider_select_code_pkg::ST_SETTLE: begin
                  timer <= timer - 16'h0001;
                  if (timer == 16'h0001) state <= divider_select_code_pkg::ST_ALIGNED;
               end
            endcase
         end
      end
   end

   // ======================================
   // Outputs
   assign divided_o                 = q3;
   assign divider_powered_o         = div_pwr;
   assign powered_down_o            = sleep;
   assign divider_ratio_o           = code_valid ? ratio_full[9:0] : 10'h000;
   assign feedback_extra_division_o = extra;
   assign output_a_current_o        = drive(outsel[divider_select_code_pkg::OUT_PA_LSB +: 6]);
   assign output_b_current_o        = drive(outsel[divider_select_code_pkg::OUT_PB_LSB +: 6]);
   assign phase_aligned_o           = state == divider_select_code_pkg::ST_ALIGNED;
endmodule
`default_nettype wire

//--- dv/divider_select_code_props.sv
// Port-level checks on the channel divider block
`default_nettype none
module divider_select_code_props #(
   parameter int CAL_CYCLES_P = 4
) (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_ack_o,
   input wire logic       divided_o,
   input wire logic       divider_powered_o,
   input wire logic       powered_down_o,
   input wire logic [9:0] divider_ratio_o,
   input wire logic [2:0] feedback_extra_division_o,
   input wire logic [5:0] output_a_current_o,
   input wire logic [5:0] output_b_current_o,
   input wire logic       sync_retimed_o,
   input wire logic       phase_aligned_o
);
   // ======================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [15:0] low_cnt;
   // Saturates so a long unaligned stretch never wraps to a small count
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) low_cnt <= 16'h0000;
      else if (phase_aligned_o || powered_down_o) low_cnt <= 16'h0000;
      else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h0001;
   end
   property p_ratio_set;
      divider_ratio_o inside {10'h000, 10'h002, 10'h004, 10'h006, 10'h008, 10'h00C, 10'h010, 10'h018, 10'h020,
         10'h030, 10'h040, 10'h048, 10'h060, 10'h080, 10'h0C0, 10'h100, 10'h180, 10'h200, 10'h300};
   endproperty
   a_ratio_set: assert property (p_ratio_set) else $error("ratio outside table");
   property p_extra_set;
      feedback_extra_division_o inside {3'h1, 3'h4, 3'h6};
   endproperty
   a_extra_set: assert property (p_extra_set) else $error("extra division illegal");
   property p_extra_six;
      feedback_extra_division_o == 3'h6 |-> divider_ratio_o % 10'h003 == 10'h000
         && !(divider_ratio_o inside {10'h018, 10'h0C0});
   endproperty
   a_extra_six: assert property (p_extra_six) else $error("extra six on wrong ratio");
   property p_drive_a;
      !(output_a_current_o inside {[6'h20:6'h2F]});
   endproperty
   a_drive_a: assert property (p_drive_a) else $error("drive A redundant state");
   property p_drive_b;
      !(output_b_current_o inside {[6'h20:6'h2F]});
   endproperty
   a_drive_b: assert property (p_drive_b) else $error("drive B redundant state");
   property p_div_hold;
      !divider_powered_o [*3] |-> $stable(divided_o);
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("divider ran unpowered");
   property p_sleep;
      powered_down_o ##1 powered_down_o |-> !phase_aligned_o;
   endproperty
   a_sleep: assert property (p_sleep) else $error("aligned while asleep");
   property p_cal_wait;
      $rose(phase_aligned_o) |-> low_cnt >= CAL_CYCLES_P;
   endproperty
   a_cal_wait: assert property (p_cal_wait) else $error("aligned before calibration");
   property p_retime;
      sync_retimed_o |=> !sync_retimed_o;
   endproperty
   a_retime: assert property (p_retime) else $error("retimed sync too long");
   property p_ack;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack longer than one cycle");
endmodule
bind output_channel_divider_sync divider_select_code_props #(.CAL_CYCLES_P(CAL_CYCLES_P)) i_divider_select_code_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_ack_o(wb_ack_o), .divided_o(divided_o),
   .divider_powered_o(divider_powered_o), .powered_down_o(powered_down_o),
   .divider_ratio_o(divider_ratio_o), .feedback_extra_division_o(feedback_extra_division_o),
   .output_a_current_o(output_a_current_o), .output_b_current_o(output_b_current_o),
   .sync_retimed_o(sync_retimed_o), .phase_aligned_o(phase_aligned_o));
`default_nettype wire

//--- dv/ref_source.sv
// Reference clock and oscillator stand-in beside the block
`default_nettype none
module ref_source (
   input  wire logic clk_i,
   output logic      reference_input_o,
   output logic      vco_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ======================================
   // Free-running sources
   logic [2:0] phase = 3'h0;
   always @(posedge clk_i) begin
      phase <= phase + 3'h1;
   end
   assign reference_input_o = phase[2];
   assign vco_o             = phase[0];
endmodule
`default_nettype wire

//--- dv/output_channel_divider_sync_tb.sv
// Self-checking bench for the channel divider block
`default_nettype none
module output_channel_divider_sync_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ======================================
   // Bench
   logic        clk_i, rst_i, cyc, stb, we, ce, sync, ref_in, vco, divd, dpw, pdn, rtm, algn, ack, err, last_err;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, dato;
   logic [9:0]  ratio;
   logic [2:0]  extra;
   logic [5:0]  cur_a, cur_b, lv, lvb;
   int          errors = 0, n_compared = 0, n;
   logic [9:0]  rtab[19] = '{10'h002, 10'h004, 10'h006, 10'h008, 10'h00C, 10'h010, 10'h018, 10'h020, 10'h030,
      10'h040, 10'h048, 10'h060, 10'h080, 10'h0C0, 10'h100, 10'h180, 10'h200, 10'h300, 10'h000};
   logic [3:0]  otab[5] = '{4'h4, 4'h1, 4'h9, 4'h6, 4'h5};
   logic        ptab[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
   output_channel_divider_sync #(.CAL_CYCLES_P(4)) i_output_channel_divider_sync (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack), .wb_err_o(err),
      .chip_enable_i(ce), .reference_input_i(ref_in), .sync_pin_i(sync), .vco_in_i(vco),
      .divided_o(divd), .divider_powered_o(dpw), .powered_down_o(pdn), .divider_ratio_o(ratio),
      .feedback_extra_division_o(extra), .output_a_current_o(cur_a), .output_b_current_o(cur_b),
      .sync_retimed_o(rtm), .phase_aligned_o(algn));
   ref_source i_ref_source (.clk_i(clk_i), .reference_input_o(ref_in), .vco_o(vco));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One classic cycle; waits for ack or err, bounded
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && err !== 1'b1 && k < 50);
      if (ack !== 1'b1 && err !== 1'b1) check("bus answer", 1, 0);
      rdat = dato;
      last_err = err;
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   task automatic wait_flag(input int lim);
      n = 0;
      while (n < lim && algn !== 1'b1) begin
         @(negedge clk_i);
         n++;
      end
   endtask
   task automatic report_and_stop();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #(25ns * 20000);
      errors++;
      report_and_stop();
   end
   initial begin
      cyc = 0; stb = 0; we = 0; adr = 0; sel = 4'hF; wdat = 0; ce = 1; sync = 0; rst_i = 1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, divider_select_code_pkg::ADDR_OUTPUT, 0);
      check("output reset", divider_select_code_pkg::OUTPUT_RESET, rdat);
      wb(0, divider_select_code_pkg::ADDR_SETTLE, 0);
      check("settle reset", divider_select_code_pkg::SETTLE_RESET, rdat);
      check("awake", 0, 32'(pdn));
      wb(1, divider_select_code_pkg::ADDR_OUTPUT, 32'h00000004);
      wb(1, divider_select_code_pkg::ADDR_CONTROL, 32'h00000004);
      // stand-in oscillator toggles every clock, so toggles are only counted for the two smallest ratios
      for (int c = 0; c < 19; c++) begin
         wb(1, divider_select_code_pkg::ADDR_DIVIDER, 32'(c));
         check("ratio", 32'(rtab[c]), 32'(ratio));
         if (c < 18) check("extra", (rtab[c] % 3 == 0 && rtab[c] != 24 && rtab[c] != 192) ? 6 : 4, 32'(extra));
         if (c < 2) begin
            repeat (8) @(negedge clk_i);
            n = 0;
            lv[0] = divd;
            repeat (64) begin
               @(negedge clk_i);
               if (divd !== lv[0]) n++;
               lv[0] = divd;
            end
            check("toggles", 1, 32'(n >= 32 / rtab[c] - 1 && n <= 32 / rtab[c] + 1));
         end
      end
      wb(1, divider_select_code_pkg::ADDR_DIVIDER, 32'h00000000);
      foreach (otab[i]) begin
         wb(1, divider_select_code_pkg::ADDR_OUTPUT, {28'h0, otab[i]});
         check("div power", 32'(ptab[i]), 32'(dpw));
      end
      check("extra direct", 1, 32'(extra));
      for (int i = 0; i < 64; i += 5) begin
         lv = 6'(i);
         lvb = ~lv;
         wb(1, divider_select_code_pkg::ADDR_OUTPUT, {10'h000, lvb, 2'h0, lv, 8'h05});
         check("drive a", (lv >= 32 && lv <= 47) ? lv - 16 : lv, 32'(cur_a));
         check("drive b", (lvb >= 32 && lvb <= 47) ? lvb - 16 : lvb, 32'(cur_b));
      end
      wb(1, divider_select_code_pkg::ADDR_SETTLE, 32'h00030004);
      // wrong seeds on purpose, outside the band
      wb(1, divider_select_code_pkg::ADDR_CAL, 32'hFFFFFFFF);
      wb(1, divider_select_code_pkg::ADDR_CONTROL, 32'h0000000E);
      wait_flag(400);
      check("aligned", 1, 32'(algn));
      @(posedge clk_i);
      sync <= 1'b1;
      n = 0;
      repeat (40) begin
         @(negedge clk_i);
         if (rtm === 1'b1) n++;
      end
      check("retimed pulses", 1, 32'(n));
      @(posedge clk_i);
      sync <= 1'b0;
      wb(1, divider_select_code_pkg::ADDR_CONTROL, 32'h0000000F);
      repeat (3) @(posedge clk_i);
      check("sleep", 1, 32'(pdn));
      check("not aligned", 0, 32'(algn));
      wb(1, divider_select_code_pkg::ADDR_CONTROL, 32'h0000000C);
      check("wake", 0, 32'(pdn));
      ce <= 1'b0;
      repeat (5) @(posedge clk_i);
      check("pin sleep", 1, 32'(pdn));
      ce <= 1'b1;
      repeat (5) @(posedge clk_i);
      check("pin wake", 0, 32'(pdn));
      wb(1, divider_select_code_pkg::ADDR_CONTROL, 32'h0000000E);
      wait_flag(400);
      wb(0, divider_select_code_pkg::ADDR_STATUS, 0);
      check("status aligned", 1, 32'(rdat[4]));
      wb(0, 8'h20, 0);
      check("unmapped err", 1, 32'(last_err));
      report_and_stop();
   end
endmodule
`default_nettype wire
